// File: hdl/hnd_cfg.svh
// Constants of the queued command dispatch and recovery block
// What this block does
// R01 - ERR clear to idle, ERR set to reset
// R02 - Reset state sends log page read
// R03 - Wait for DRQ set, BSY clear
// R04 - Any detection method for that condition
// R05 - Receive sense data, then error flush
// R06 - Flush retires failed command, back idle
// R07 - Flush frees every allocated tag
// R08 - Pending commands error-completed or reissued
// R09 - Idle awaits command, interrupt, free tag
// R10 - Untagged command and free tag: preset
// R11 - Tagged command, BSY clear, no data: issue
// R12 - Drive interrupt goes to interrupt service
// R13 - Otherwise stay idle
// R14 - Preset assigns tag, sets its SActive bit
// R15 - Issue sends command; deferred stays unissued
// R16 - Service reads status, keeps captured copy
// R17 - Retire cleared tags, update copy, then test
// R18 - Priority: interrupt, issue, then preset
// R19 - Thirty-two tags, free, assigned or issued
`ifndef HND_CFG_SVH
`define HND_CFG_SVH
// Register byte offsets
`define HND_REG_CTRL 8'h00
`define HND_REG_STAT 8'h04
`define HND_REG_MASK 8'h08
`define HND_REG_STATE 8'h0C
`define HND_REG_SACT 8'h10
`define HND_REG_CAPT 8'h14
// Control fields and reset value
`define HND_CTRL_EN 0
`define HND_CTRL_REISSUE 1
`define HND_CTRL_RST 2'h0
// Event bits of status and mask
`define HND_EV_CMPL 0
`define HND_EV_ERR 1
`define HND_EV_FLUSH 2
`define HND_EV_RST 3'h0
// Drive status bits
`define HND_ST_ERR 0
`define HND_ST_DRQ 3
`define HND_ST_BSY 7
// Error log page requested on recovery
`define HND_LOG_PAGE 8'h10
`endif

// File: hdl/hnd_pkg.sv
// Types of the queued command dispatch and recovery block
package hnd_pkg;
	// Controller states, one-hot
	typedef enum logic [10:0] {
		queue_idle_state = 11'h001,
		tag_preset_state = 11'h002,
		command_issue_state = 11'h004,
		interrupt_service_state = 11'h008,
		cmp_check_state = 11'h010,
		cmp_retire_state = 11'h020,
		error_test_state = 11'h040,
		queue_reset_state = 11'h080,
		cleanup_wait_state = 11'h100,
		sense_receive_state = 11'h200,
		error_flush_state = 11'h400
	} hnd_state_type;
	// Per-tag condition
	typedef enum logic [1:0] {
		tag_free = 2'h0,
		tag_assigned = 2'h1,
		tag_issued = 2'h2
	} hnd_tag_type;
endpackage

// File: hdl/hnd_dispatch.sv
// Queued command dispatch and error recovery controller
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`include "hnd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module hnd_dispatch (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	output logic cmd_ready,
	input wire logic dev_intr,
	input wire logic [7:0] dev_status,
	input wire logic [31:0] dev_sactive,
	input wire logic fpdma_phase,
	output logic status_rd,
	output logic tx_valid,
	input wire logic tx_accept,
	output logic tx_log,
	output logic tx_write,
	output logic [4:0] tx_tag,
	output logic [7:0] tx_page,
	input wire logic pio_done,
	input wire logic [4:0] sense_tag,
	output logic sact_set,
	output logic [4:0] sact_set_tag,
	output logic [31:0] retire_vec,
	output logic retire_err,
	output logic retire_reissue,
	output logic fail_valid,
	output logic [4:0] fail_tag,
	output logic [7:0] fail_status
);
	import hnd_pkg::*;

	hnd_state_type state_q, state_d; // Controller state
	hnd_tag_type tag_q [32]; // Tag pool
	logic [31:0] wr_q; // Direction per tag
	logic [31:0] alloc, asg_vec, iss_vec, done_vec; // Pool views
	logic [31:0] sact_copy_q; // Stored SActive copy
	logic [7:0] capt_q; // captured_status_copy
	logic [4:0] sel_tag_q; // Tag in work
	logic [4:0] sense_q; // Failed tag from sense data
	logic wait_valid_q, wait_wr_q; // Command awaiting a tag
	logic want_issue, want_preset, en;
	logic [1:0] ctrl_q; // Enable, reissue mode
	logic [2:0] stat_q, mask_q, ev; // Interrupt registers
	logic dp_valid_q, dp_write_q; // Bus data phase
	logic [7:0] dp_addr_q;

	// Lowest set bit index
	function automatic logic [4:0] lowest(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// Pool views
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			alloc[i] = tag_q[i] != tag_free; // R19
			asg_vec[i] = tag_q[i] == tag_assigned;
			iss_vec[i] = tag_q[i] == tag_issued;
		end
	end

	// Tags the drive has newly cleared
	assign done_vec = sact_copy_q & ~dev_sactive & iss_vec; // R17
	assign en = ctrl_q[`HND_CTRL_EN];
	assign want_preset = wait_valid_q & ~&alloc; // R10
	// Status may be polled or interrupt-led; plain level check here
	assign want_issue = |asg_vec & ~dev_status[`HND_ST_BSY] & ~fpdma_phase; // R11

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			queue_idle_state: begin
				if (en && dev_intr) begin
					state_d = interrupt_service_state; // R12 R18
				end else if (en && want_issue) begin
					state_d = command_issue_state; // R11 R18
				end else if (en && want_preset) begin
					state_d = tag_preset_state; // R10
				end // R09 R13
			end
			tag_preset_state: state_d = queue_idle_state; // R14
			command_issue_state: state_d = queue_idle_state; // R15
			interrupt_service_state: state_d = cmp_check_state;
			cmp_check_state: begin
				// Retire before the error test
				state_d = |done_vec ? cmp_retire_state : error_test_state; // R17
			end
			cmp_retire_state: state_d = error_test_state;
			error_test_state: begin
				if (capt_q[`HND_ST_ERR]) begin
					state_d = queue_reset_state; // R01
				end else begin
					state_d = queue_idle_state; // R01
				end
			end
			queue_reset_state: state_d = cleanup_wait_state; // R02
			cleanup_wait_state: begin
				if (dev_status[`HND_ST_DRQ] && !dev_status[`HND_ST_BSY]) begin
					state_d = sense_receive_state; // R03 R04
				end
			end
			sense_receive_state: begin
				if (pio_done) begin
					state_d = error_flush_state; // R05
				end
			end
			error_flush_state: state_d = queue_idle_state; // R06
			default: state_d = queue_idle_state;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= queue_idle_state;
		end else begin
			state_q <= state_d;
		end
	end

	// Tag chosen while idle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_tag_q <= 5'h00;
		end else if (state_q == queue_idle_state) begin
			sel_tag_q <= want_issue ? lowest(asg_vec) : lowest(~alloc);
		end
	end

	// Tag pool updates
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				tag_q[i] <= tag_free;
			end
			wr_q <= 32'h0;
		end else begin
			case (state_q)
				tag_preset_state: begin
					tag_q[sel_tag_q] <= tag_assigned; // R14
					wr_q[sel_tag_q] <= wait_wr_q;
				end
				command_issue_state: begin
					if (tx_accept) begin
						tag_q[sel_tag_q] <= tag_issued; // R15
					end
				end
				cmp_retire_state: begin
					for (int i = 0; i < 32; i++) begin
						if (done_vec[i]) begin
							tag_q[i] <= tag_free; // R17
						end
					end
				end
				error_flush_state: begin
					for (int i = 0; i < 32; i++) begin
						tag_q[i] <= tag_free; // R07
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Stored SActive copy
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sact_copy_q <= 32'h0;
		end else if (state_q == tag_preset_state) begin
			sact_copy_q[sel_tag_q] <= 1'b1; // R14
		end else if (state_q == cmp_retire_state) begin
			sact_copy_q <= dev_sactive; // R17
		end else if (state_q == error_flush_state) begin
			sact_copy_q <= 32'h0; // R07
		end
	end

	// Command waiting for a tag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wait_valid_q <= 1'b0;
			wait_wr_q <= 1'b0;
		end else if (cmd_valid && cmd_ready) begin
			wait_valid_q <= 1'b1;
			wait_wr_q <= cmd_write;
		end else if (state_q == tag_preset_state) begin
			wait_valid_q <= 1'b0;
		end
	end

	// Captured status and failed tag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			capt_q <= 8'h00;
			sense_q <= 5'h00;
		end else begin
			if (state_q == interrupt_service_state) begin
				capt_q <= dev_status; // R16
			end
			if (state_q == sense_receive_state && pio_done) begin
				sense_q <= sense_tag; // R05
			end
		end
	end

	// Retirement reports, one cycle after the state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			retire_vec <= 32'h0;
			retire_err <= 1'b0;
			retire_reissue <= 1'b0;
			fail_valid <= 1'b0;
			fail_tag <= 5'h00;
			fail_status <= 8'h00;
		end else begin
			retire_vec <= 32'h0;
			retire_err <= 1'b0;
			retire_reissue <= 1'b0;
			fail_valid <= 1'b0;
			if (state_q == cmp_retire_state) begin
				retire_vec <= done_vec; // R17
			end else if (state_q == error_flush_state) begin
				retire_vec <= alloc & ~(32'h1 << sense_q); // R08
				retire_err <= ~ctrl_q[`HND_CTRL_REISSUE]; // R08
				retire_reissue <= ctrl_q[`HND_CTRL_REISSUE]; // R08
				fail_valid <= 1'b1; // R06
				fail_tag <= sense_q;
				fail_status <= capt_q; // R06
			end
		end
	end

	// Handshakes toward the link and the upper layer
	assign cmd_ready = ~wait_valid_q;
	assign status_rd = state_q == interrupt_service_state; // R16
	assign tx_valid = state_q == command_issue_state || state_q == queue_reset_state;
	assign tx_log = state_q == queue_reset_state; // R02
	assign tx_page = `HND_LOG_PAGE;
	assign tx_tag = sel_tag_q;
	assign tx_write = wr_q[sel_tag_q];
	assign sact_set = state_q == tag_preset_state; // R14
	assign sact_set_tag = sel_tag_q;

	// Interrupt events
	assign ev[`HND_EV_CMPL] = state_q == cmp_retire_state;
	assign ev[`HND_EV_ERR] = state_q == error_test_state && capt_q[`HND_ST_ERR];
	assign ev[`HND_EV_FLUSH] = state_q == error_flush_state;
	assign irq = |(stat_q & mask_q);

	// Bus address phase capture
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (hready) begin
			dp_valid_q <= hsel & htrans[1] & (hsize == 3'h2);
			dp_write_q <= hwrite;
			dp_addr_q <= haddr[7:0];
		end
	end

	// Control and mask registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `HND_CTRL_RST;
			mask_q <= `HND_EV_RST;
		end else if (dp_valid_q && dp_write_q) begin
			if (dp_addr_q == `HND_REG_CTRL) begin
				ctrl_q <= hwdata[1:0];
			end
			if (dp_addr_q == `HND_REG_MASK) begin
				mask_q <= hwdata[2:0];
			end
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stat_q <= `HND_EV_RST;
		end else if (dp_valid_q && dp_write_q && dp_addr_q == `HND_REG_STAT) begin
			stat_q <= (stat_q & ~hwdata[2:0]) | ev;
		end else begin
			stat_q <= stat_q | ev;
		end
	end

	// Read data mux of registers
	always_comb begin
		hrdata = 32'h0;
		if (dp_valid_q && !dp_write_q) begin
			case (dp_addr_q)
				`HND_REG_CTRL: hrdata = {30'h0, ctrl_q};
				`HND_REG_STAT: hrdata = {29'h0, stat_q};
				`HND_REG_MASK: hrdata = {29'h0, mask_q};
				`HND_REG_STATE: hrdata = {21'h0, state_q};
				`HND_REG_SACT: hrdata = sact_copy_q;
				`HND_REG_CAPT: hrdata = {24'h0, capt_q};
				default: hrdata = 32'h0;
			endcase
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_err_exit: assert property (state_q == error_test_state |=> // R01
		state_q == ($past(capt_q[0]) ? queue_reset_state : queue_idle_state))
		else $error("Error test exit wrong");
	chk_log_request: assert property (state_q == queue_reset_state |-> // R02
		tx_valid && tx_log && tx_page == 8'h10 ##1 state_q == cleanup_wait_state)
		else $error("Log request not sent");
	chk_cleanup_hold: assert property (state_q == cleanup_wait_state && // R03
		(!dev_status[3] || dev_status[7]) |=> state_q == cleanup_wait_state)
		else $error("Left cleanup wait early");
	chk_sense_flush: assert property (state_q == sense_receive_state && pio_done // R05
		|=> state_q == error_flush_state ##1 state_q == queue_idle_state)
		else $error("Sense to flush wrong");
	chk_flush_free: assert property (state_q == error_flush_state |=> // R07
		alloc == 32'h0 && fail_valid && fail_status == $past(capt_q))
		else $error("Flush left tags");
	chk_preset_sact: assert property (state_q == tag_preset_state |=> // R14
		sact_copy_q[$past(sel_tag_q)] && tag_q[$past(sel_tag_q)] == tag_assigned)
		else $error("Preset did not set tag");
	chk_issue_mark: assert property (state_q == command_issue_state |=> // R15
		tag_q[$past(sel_tag_q)] == ($past(tx_accept) ? tag_issued : tag_assigned))
		else $error("Issue marking wrong");
	chk_issue_gate: assert property (state_q == queue_idle_state && // R11
		(dev_status[7] || fpdma_phase) |=> state_q != command_issue_state)
		else $error("Issue while blocked");
	chk_intr_first: assert property (state_q == queue_idle_state && en && dev_intr // R18
		|=> state_q == interrupt_service_state)
		else $error("Interrupt not first");
	chk_status_read: assert property (state_q == interrupt_service_state |-> // R16
		status_rd ##1 capt_q == $past(dev_status) && state_q == cmp_check_state)
		else $error("Status not captured");
endmodule
`default_nettype wire

// File: testbench/hnd_drive_model.sv
// Behavioural drive model facing the dispatch block
`timescale 1ns/1ps
`default_nettype none
module hnd_drive_model #(
	parameter logic [4:0] SENSE_TAG = 5'h01
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic intr_req,
	input wire logic err_req,
	input wire logic [31:0] done_mask,
	input wire logic status_rd,
	input wire logic tx_valid,
	input wire logic tx_log,
	input wire logic sact_set,
	input wire logic [4:0] sact_set_tag,
	output logic dev_intr,
	output logic [7:0] dev_status,
	output logic [31:0] dev_sactive,
	output logic pio_done,
	output logic [4:0] sense_tag
);
	logic [3:0] cnt_q; // Busy time before sense data
	assign sense_tag = SENSE_TAG;
	// Interrupt pending until status is read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) dev_intr <= 1'b0;
		else if (intr_req) dev_intr <= 1'b1;
		else if (status_rd) dev_intr <= 1'b0;
	end
	// Active tags, all dropped on error recovery
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) dev_sactive <= 32'h0;
		else if (tx_valid && tx_log) dev_sactive <= 32'h0;
		else if (intr_req) dev_sactive <= dev_sactive & ~done_mask;
		else if (sact_set) dev_sactive[sact_set_tag] <= 1'b1;
	end
	// Busy after log request, then data ready, then sense FIS
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 4'h0;
			dev_status <= 8'h00;
			pio_done <= 1'b0;
		end else begin
			pio_done <= (cnt_q == 4'h1);
			if (intr_req) dev_status <= {7'h0, err_req};
			else if (tx_valid && tx_log) begin
				cnt_q <= 4'hF;
				dev_status <= 8'h81;
			end else if (cnt_q != 4'h0) begin
				cnt_q <= cnt_q - 4'h1;
				if (cnt_q == 4'h6) dev_status <= 8'h09;
				if (cnt_q == 4'h1) dev_status <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the dispatch and recovery block
`include "hnd_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dev_sactive, retire_vec, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, irq, cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, dev_intr;
	logic [7:0] dev_status, tx_page, fail_status, fl_st, log_pg;
	logic fpdma_phase = 1'b0, status_rd, tx_valid, tx_accept = 1'b0, tx_log, tx_write;
	logic [4:0] tx_tag, sense_tag, sact_set_tag, fail_tag, fl_tag, sact_tag, iss_tag;
	logic pio_done, sact_set, retire_err, retire_reissue, fail_valid, fl_err, fl_re, iss_wr;
	logic intr_req = 1'b0, err_req = 1'b0;
	logic [31:0] done_mask = 32'h0, fl_vec, ret_vec;
	int error_cnt = 0, num_checks = 0, sact_cnt = 0, log_cnt = 0, iss_cnt = 0;
	int def_cnt = 0, ret_cnt = 0, fl_cnt = 0;
	// Clock of 5 ns
	always #2.5 ref_clk = ~ref_clk;
	hnd_dispatch u_hnd_dispatch (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_ready(cmd_ready),
		.dev_intr(dev_intr), .dev_status(dev_status), .dev_sactive(dev_sactive),
		.fpdma_phase(fpdma_phase), .status_rd(status_rd), .tx_valid(tx_valid),
		.tx_accept(tx_accept), .tx_log(tx_log), .tx_write(tx_write), .tx_tag(tx_tag),
		.tx_page(tx_page), .pio_done(pio_done), .sense_tag(sense_tag), .sact_set(sact_set),
		.sact_set_tag(sact_set_tag), .retire_vec(retire_vec), .retire_err(retire_err),
		.retire_reissue(retire_reissue), .fail_valid(fail_valid), .fail_tag(fail_tag),
		.fail_status(fail_status));
	hnd_drive_model u_hnd_drive_model (.ref_clk(ref_clk), .rst(rst), .intr_req(intr_req),
		.err_req(err_req), .done_mask(done_mask), .status_rd(status_rd),
		.tx_valid(tx_valid), .tx_log(tx_log), .sact_set(sact_set),
		.sact_set_tag(sact_set_tag), .dev_intr(dev_intr), .dev_status(dev_status),
		.dev_sactive(dev_sactive), .pio_done(pio_done), .sense_tag(sense_tag));
	// Event monitor of the block's pulses
	always @(posedge ref_clk) begin
		if (sact_set === 1'b1) begin
			sact_cnt <= sact_cnt + 1;
			sact_tag <= sact_set_tag;
		end
		if (tx_valid === 1'b1 && tx_log === 1'b1) begin
			log_cnt <= log_cnt + 1;
			log_pg <= tx_page;
		end else if (tx_valid === 1'b1 && tx_accept) begin
			iss_cnt <= iss_cnt + 1;
			iss_tag <= tx_tag;
			iss_wr <= tx_write;
		end else if (tx_valid === 1'b1) def_cnt <= def_cnt + 1;
		if (|retire_vec === 1'b1 && fail_valid !== 1'b1) begin
			ret_cnt <= ret_cnt + 1;
			ret_vec <= retire_vec;
		end
		if (fail_valid === 1'b1) begin
			fl_cnt <= fl_cnt + 1;
			{fl_vec, fl_err, fl_re, fl_tag, fl_st} <=
				{retire_vec, retire_err, retire_reissue, fail_tag, fail_status};
		end
	end
	// Verdict and end of run
	task automatic end_sim();
		if (error_cnt == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Count compare, bounded wait for an event counter
	task automatic wait_for(ref int v, input int n);
		int k;
		k = 0;
		while (v < n && k < 300) begin
			@(posedge ref_clk);
			k++;
		end
		chk(v, n);
	endtask
	// One AHB single word transfer
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		rd = hrdata;
	endtask
	// Hand one command over
	task automatic submit(input logic w);
		do @(posedge ref_clk); while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b1;
		cmd_write <= w;
		@(posedge ref_clk);
		cmd_valid <= 1'b0;
	endtask
	// Drive raises an interrupt
	task automatic intr(input logic [31:0] m, input logic e);
		intr_req <= 1'b1;
		err_req <= e;
		done_mask <= m;
		@(posedge ref_clk);
		intr_req <= 1'b0;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		end_sim();
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		ahb(1'b1, `HND_REG_STATE, 32'hFF);
		for (int i = 0; i < 7; i++) begin
			ahb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, (i == 3) ? 32'h1 : 32'h0);
		end
		ahb(1'b1, `HND_REG_CTRL, 32'h1);
		ahb(1'b1, `HND_REG_MASK, 32'h7);
		submit(1'b1);
		wait_for(sact_cnt, 1);
		chk(sact_tag, 32'h0);
		wait_for(def_cnt, 1);
		// Idle may already have chosen one more deferred issue at this edge
		fpdma_phase <= 1'b1;
		repeat (2) @(posedge ref_clk);
		tx_accept <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk(iss_cnt, 0);
		fpdma_phase <= 1'b0;
		wait_for(iss_cnt, 1);
		chk({iss_wr, iss_tag}, 32'h20);
		submit(1'b0);
		wait_for(iss_cnt, 2);
		chk({iss_wr, iss_tag}, 32'h01);
		intr(32'h1, 1'b0);
		wait_for(ret_cnt, 1);
		chk(ret_vec, 32'h1);
		ahb(1'b0, `HND_REG_SACT, 32'h0);
		chk(rd, 32'h2);
		ahb(1'b0, `HND_REG_STATE, 32'h0);
		chk(rd, 32'h1);
		chk(irq, 1'b1);
		ahb(1'b1, `HND_REG_MASK, 32'h0);
		@(posedge ref_clk);
		chk(irq, 1'b0);
		ahb(1'b1, `HND_REG_MASK, 32'h7);
		ahb(1'b1, `HND_REG_STAT, 32'h1);
		@(posedge ref_clk);
		chk(irq, 1'b0);
		for (int i = 0; i < 2; i++) begin
			ahb(1'b1, `HND_REG_CTRL, {30'h0, i[0], 1'b1});
			submit(1'b0);
			wait_for(iss_cnt, 3 + i);
			intr(32'h0, 1'b1);
			wait_for(log_cnt, 1 + i);
			chk(log_pg, 32'h10);
			ahb(1'b0, `HND_REG_STATE, 32'h0);
			chk(rd, 32'h100);
			wait_for(fl_cnt, 1 + i);
			chk({fl_tag, fl_st}, {19'h0, 5'h01, 8'h01});
			chk(fl_vec, 32'h1);
			chk({fl_err, fl_re}, {30'h0, ~i[0], i[0]});
			ahb(1'b0, `HND_REG_STATE, 32'h0);
			chk(rd, 32'h1);
			ahb(1'b1, `HND_REG_STAT, 32'h7);
		end
		end_sim();
	end
endmodule
`default_nettype wire
